// ### design/spnv_defines.svh
// Opcodes, status layout, guard limits and timing for the serial nonvolatile access block
`ifndef SPNV_DEFINES_SVH
`define SPNV_DEFINES_SVH

`define SPNV_OP_ARM       8'h06
`define SPNV_OP_DISARM    8'h04
`define SPNV_OP_FETCH     8'h05
`define SPNV_OP_STORE     8'h01
`define SPNV_OP_READ      8'h03
`define SPNV_OP_WRITE     8'h02
`define SPNV_OP_SLEEP     8'hB9

`define SPNV_SR_PEN       7
`define SPNV_SR_BP1       3
`define SPNV_SR_BP0       2
`define SPNV_SR_WEL       1
`define SPNV_SR_FIXED     8'h40
`define SPNV_GUARD_RESET  3'h0

`define SPNV_AW           18
`define SPNV_ADDR_BYTES   2'h2
`define SPNV_ADDR_LAST    18'h3FFFF
`define SPNV_GUARD_QTR    18'h30000
`define SPNV_GUARD_HALF   18'h20000

`define SPNV_CLK_MHZ      50
`define SPNV_WAKE_REC_US  400
`define SPNV_WAKE_CYCLES  (`SPNV_WAKE_REC_US * `SPNV_CLK_MHZ)
`define SPNV_WAKE_W       20

`endif

// ### design/spnv_pkg.sv
// Types and shared decode for the serial nonvolatile access block
`include "spnv_defines.svh"
package spnv_pkg;
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_RDATA, PH_WDATA, PH_SFETCH, PH_SSTORE,
                            PH_IDLE} spnv_phase_type;
  typedef enum logic [2:0] {RES_NONE, RES_ARM, RES_DISARM, RES_STORE, RES_WRITE,
                            RES_SLEEP} spnv_res_type;
  typedef struct packed {
    spnv_phase_type       phase;
    logic [2:0]           bits;
    logic [1:0]           nbyte;
    logic [6:0]           sr;
    logic [`SPNV_AW-1:0]  addr;
    logic                 is_write;
    logic                 stuck;
    spnv_res_type         res;
    logic [7:0]           store_byte;
    logic                 store_ok;
    logic                 wr_tog;
    logic [7:0]           wdata;
    logic [`SPNV_AW-1:0]  waddr;
    logic [4:0]           s1;
    logic [4:0]           s2;
  } spnv_link_type;
  typedef struct packed {
    logic                 cs1, cs2, cs3;
    logic                 wp1, wp2;
    logic                 t1, t2, t3;
    logic                 write_enable_latch_flag, pen;
    logic [1:0]           bp;
    logic                 asleep, waking;
    logic [`SPNV_WAKE_W-1:0] wcnt;
    logic                 loaded;
    logic                 mem_we;
    logic [`SPNV_AW-1:0]  mem_waddr;
    logic [7:0]           mem_wdata;
    logic                 nv_we;
  } spnv_ctrl_type;
  // Block-guard range check, (hi,lo) pair against an array address
  function automatic logic spnv_guarded(input logic [`SPNV_AW-1:0] a, input logic [1:0] bp);
    logic g;
    g = 1'b0;
    unique case (bp)
      2'b00: g = 1'b0;
      2'b01: g = (a >= `SPNV_GUARD_QTR);
      2'b10: g = (a >= `SPNV_GUARD_HALF);
      2'b11: g = 1'b1;
    endcase
    return g;
  endfunction
endpackage

// ### design/spnv_top.sv
// Serial command, protection and sleep logic of a nonvolatile byte memory
`timescale 1ns/1ps
`default_nettype none

module spnv_link
  import spnv_pkg::*;
(
  input  wire logic                sck,          // Link clock from master
  input  wire logic                rst_n,        // Power-on reset, async low
  input  wire logic                cs_n,         // Chip select pin
  input  wire logic                si,           // Serial input
  input  wire logic                hold_n,       // Pause pin
  input  wire logic [4:0]          ctl,          // {busy,wel,pen,bp1,bp0} from clk side
  input  wire logic [7:0]          mem_rdata,    // Array read data at mem_raddr
  output logic                     so,           // Serial output
  output logic                     so_oe_n,      // Serial output enable, low drives
  output logic [`SPNV_AW-1:0]      mem_raddr,    // Array read address
  output logic                     mode3,        // Mode 3 caught at select fall
  output spnv_res_type             res,          // Frame result for select rise
  output logic [7:0]               store_byte,   // Status store data byte
  output logic                     store_ok,     // Store byte complete
  output logic                     wr_tog,       // Toggles once per accepted write byte
  output logic [`SPNV_AW-1:0]      waddr,        // Accepted write address
  output logic [7:0]               wdata         // Accepted write data
);
  spnv_link_type q, d;
  logic          fresh;
  logic [6:0]    osr;
  logic [7:0]    stat;
  logic [7:0]    byte_in;
  logic          out_phase;

  // First edge of a frame: preset while select is high
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      fresh <= 1'b1;
    end else if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= ~hold_n & fresh;
    end
  end

  // Clock level when select falls picks the mode
  always_ff @(negedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      mode3 <= 1'b0;
    end else begin
      mode3 <= sck;
    end
  end

  // Status byte seen by the master, fixed bits from the constant
  always_comb begin
    stat                = `SPNV_SR_FIXED;
    stat[`SPNV_SR_PEN]  = q.s2[2];
    stat[`SPNV_SR_BP1]  = q.s2[1];
    stat[`SPNV_SR_BP0]  = q.s2[0];
    stat[`SPNV_SR_WEL]  = q.s2[3];
  end

  assign byte_in = {q.sr, si};

  // Input side: sample on rising edges, decode opcode, track address
  always_comb begin
    d      = q;
    d.s1   = ctl;
    d.s2   = q.s1;
    if (fresh) begin
      d.res      = RES_NONE;
      d.store_ok = 1'b0;
    end
    if (hold_n) begin
      d.sr   = byte_in[6:0];
      d.bits = fresh ? 3'h1 : q.bits + 3'h1;
      if (fresh) begin
        d.phase = PH_OPCODE;
      end else begin
        unique case (q.phase)
          PH_OPCODE: if (q.bits == 3'h7) begin
            d.phase = PH_IDLE;
            if (!q.s2[4]) begin
              unique case (byte_in)
                `SPNV_OP_ARM:    d.res = RES_ARM;
                `SPNV_OP_DISARM: d.res = RES_DISARM;
                `SPNV_OP_FETCH:  d.phase = PH_SFETCH;
                `SPNV_OP_STORE:  begin
                  d.phase = PH_SSTORE;
                  d.res   = RES_STORE;
                end
                `SPNV_OP_READ:   begin
                  d.phase    = PH_ADDR;
                  d.is_write = 1'b0;
                  d.nbyte    = 2'h0;
                end
                `SPNV_OP_WRITE:  begin
                  d.phase    = PH_ADDR;
                  d.is_write = 1'b1;
                  d.nbyte    = 2'h0;
                  d.stuck    = 1'b0;
                  d.res      = RES_WRITE;
                end
                `SPNV_OP_SLEEP:  d.res = RES_SLEEP;
                default:         d.res = RES_NONE;
              endcase
            end
          end
          PH_ADDR: if (q.bits == 3'h7) begin
            d.addr  = {q.addr[`SPNV_AW-9:0], byte_in};
            d.nbyte = q.nbyte + 2'h1;
            if (q.nbyte == `SPNV_ADDR_BYTES) begin
              d.phase = q.is_write ? PH_WDATA : PH_RDATA;
            end
          end
          PH_RDATA: if (q.bits == 3'h7) begin
            d.addr = q.addr + 18'h00001;
          end
          PH_WDATA: if (q.bits == 3'h7) begin
            if (!q.s2[3] || q.stuck || spnv_guarded(q.addr, q.s2[1:0])) begin
              d.stuck = 1'b1;
            end else begin
              d.wdata  = byte_in;
              d.waddr  = q.addr;
              d.wr_tog = ~q.wr_tog;
              d.addr   = q.addr + 18'h00001;
            end
          end
          PH_SSTORE: if (q.bits == 3'h7) begin
            d.store_byte = byte_in;
            d.store_ok   = 1'b1;
            d.phase      = PH_IDLE;
          end
          PH_SFETCH, PH_IDLE: begin
          end
        endcase
      end
    end
  end

  // Link-side state register
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{phase: PH_IDLE, res: RES_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign out_phase = (q.phase == PH_RDATA) || (q.phase == PH_SFETCH);

  // Output side: falling edges; select rise tristates at once
  always_ff @(negedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      so      <= 1'b0;
      so_oe_n <= 1'b1;
      osr     <= 7'h00;
    end else if (cs_n) begin
      so      <= 1'b0;
      so_oe_n <= 1'b1;
      osr     <= 7'h00;
    end else if (!hold_n || fresh || !out_phase) begin
      so_oe_n <= 1'b1;
    end else if (q.bits == 3'h0) begin
      so      <= (q.phase == PH_RDATA) ? mem_rdata[7] : stat[7];
      osr     <= (q.phase == PH_RDATA) ? mem_rdata[6:0] : stat[6:0];
      so_oe_n <= 1'b0;
    end else begin
      so      <= osr[6];
      osr     <= {osr[5:0], 1'b0};
      so_oe_n <= 1'b0;
    end
  end

  assign mem_raddr  = q.addr;
  assign res        = q.res;
  assign store_byte = q.store_byte;
  assign store_ok   = q.store_ok;
  assign wr_tog     = q.wr_tog;
  assign waddr      = q.waddr;
  assign wdata      = q.wdata;

  sequence s_wbyte_end;
    (q.phase == PH_WDATA) && (q.bits == 3'h7) && hold_n && !fresh;
  endsequence

  a_guard_discard: assert property (@(posedge sck) disable iff (!rst_n)
    s_wbyte_end ##0 spnv_guarded(q.addr, q.s2[1:0]) |=> $stable(q.wr_tog) && $stable(q.addr))
    else $error("guarded write byte was accepted");
  a_latch_reject: assert property (@(posedge sck) disable iff (!rst_n)
    s_wbyte_end ##0 !q.s2[3] |=> $stable(q.wr_tog) ##1 $stable(q.waddr))
    else $error("write accepted with latch clear");
  a_read_wrap: assert property (@(posedge sck) disable iff (!rst_n)
    (q.phase == PH_RDATA) && (q.bits == 3'h7) && hold_n && !fresh
      && (q.addr == `SPNV_ADDR_LAST) |=> (q.addr == 18'h00000))
    else $error("read address did not wrap");
  a_pause_freeze: assert property (@(posedge sck) disable iff (!rst_n)
    !hold_n && !fresh |=> $stable(q.bits) && $stable(q.addr) && $stable(q.sr))
    else $error("counters moved during pause");
endmodule // spnv_link

module spnv_top
  import spnv_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = `SPNV_WAKE_CYCLES  // Wake recovery in clk cycles
)(
  input  wire logic                clk,          // System clock, 50 MHz
  input  wire logic                rst_n,        // Power-on reset, async low
  input  wire logic                sck,          // Serial clock pin
  input  wire logic                cs_n,         // Chip select pin
  input  wire logic                si,           // Serial data in
  input  wire logic                hold_n,       // Pause pin
  input  wire logic                wp_n,         // Write-guard pin
  output logic                     so,           // Serial data out
  output logic                     so_oe_n,      // Low while so is driven
  output logic [`SPNV_AW-1:0]      mem_raddr,    // Array read address
  input  wire logic [7:0]          mem_rdata,    // Array read data, async
  output logic [`SPNV_AW-1:0]      mem_waddr,    // Array write address
  output logic [7:0]               mem_wdata,    // Array write data
  output logic                     mem_we,       // Array write strobe
  input  wire logic [2:0]          nv_guard_in,  // Stored {pen,bp1,bp0}
  output logic [2:0]               nv_guard,     // {pen,bp1,bp0} to store
  output logic                     nv_we,        // Nonvolatile store strobe
  output logic                     sleep_active, // Asleep or waking
  output logic                     spi_mode3     // Mode seen at last select fall
);
  spnv_ctrl_type q, d;
  spnv_res_type  res;
  logic [7:0]    store_byte;
  logic          store_ok;
  logic          wr_tog;
  logic [`SPNV_AW-1:0] waddr;
  logic [7:0]    wdata;
  logic          cs_rise;
  logic          cs_fall;

  spnv_link u_link (
    .sck        (sck),
    .rst_n      (rst_n),
    .cs_n       (cs_n),
    .si         (si),
    .hold_n     (hold_n),
    .ctl        ({q.asleep, q.write_enable_latch_flag, q.pen, q.bp}),
    .mem_rdata  (mem_rdata),
    .so         (so),
    .so_oe_n    (so_oe_n),
    .mem_raddr  (mem_raddr),
    .mode3      (spi_mode3),
    .res        (res),
    .store_byte (store_byte),
    .store_ok   (store_ok),
    .wr_tog     (wr_tog),
    .waddr      (waddr),
    .wdata      (wdata)
  );

  // Select edges after the two-stage synchroniser
  assign cs_rise = q.cs2 & ~q.cs3;
  assign cs_fall = ~q.cs2 & q.cs3;

  // Control: latch, guards, array strobe, sleep and wake
  always_comb begin
    d        = q;
    d.cs1    = cs_n;
    d.cs2    = q.cs1;
    d.cs3    = q.cs2;
    d.wp1    = wp_n;
    d.wp2    = q.wp1;
    d.t1     = wr_tog;
    d.t2     = q.t1;
    d.t3     = q.t2;
    d.mem_we = 1'b0;
    d.nv_we  = 1'b0;
    if (!q.loaded) begin
      {d.pen, d.bp} = nv_guard_in;
      d.loaded      = 1'b1;
    end
    // Link data is stable here: it changes no sooner than eight sck rising edges later
    if (q.t2 != q.t3) begin
      d.mem_we    = 1'b1;
      d.mem_waddr = waddr;
      d.mem_wdata = wdata;
    end
    // Frame results stand still while select is high
    if (cs_rise) begin
      unique case (res)
        RES_ARM:    d.write_enable_latch_flag = 1'b1;
        RES_DISARM: d.write_enable_latch_flag = 1'b0;
        RES_WRITE:  d.write_enable_latch_flag = 1'b0;
        RES_STORE:  begin
          if (q.write_enable_latch_flag && store_ok && !(q.pen && !q.wp2)) begin
            d.pen   = store_byte[`SPNV_SR_PEN];
            d.bp[1] = store_byte[`SPNV_SR_BP1];
            d.bp[0] = store_byte[`SPNV_SR_BP0];
            d.nv_we = 1'b1;
          end
          d.write_enable_latch_flag = 1'b0;
        end
        RES_SLEEP:  d.asleep = 1'b1;
        RES_NONE:   begin
        end
      endcase
    end
    if (cs_fall && q.asleep && !q.waking) begin
      d.waking = 1'b1;
      d.wcnt   = '0;
    end
    if (q.waking) begin
      d.wcnt = q.wcnt + 1'b1;
      if (q.wcnt == `SPNV_WAKE_W'(WAKE_CYCLES - 1)) begin
        d.asleep = 1'b0;
        d.waking = 1'b0;
      end
    end
  end

  // Control register; latch and guards start clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, wp1: 1'b1, wp2: 1'b1,
             bp: 2'(`SPNV_GUARD_RESET), default: '0};
    end else begin
      q <= d;
    end
  end

  assign mem_waddr    = q.mem_waddr;
  assign mem_wdata    = q.mem_wdata;
  assign mem_we       = q.mem_we;
  assign nv_guard     = {q.pen, q.bp};
  assign nv_we        = q.nv_we;
  assign sleep_active = q.asleep;

  sequence s_frame_end(spnv_res_type r);
    cs_rise && (res == r);
  endsequence

  a_latch_powerup: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> !q.write_enable_latch_flag ##1 !q.write_enable_latch_flag)
    else $error("write latch set after reset");
  a_arm_sets: assert property (@(posedge clk) disable iff (!rst_n)
    s_frame_end(RES_ARM) |=> q.write_enable_latch_flag)
    else $error("arm did not set latch");
  a_disarm_clears: assert property (@(posedge clk) disable iff (!rst_n)
    s_frame_end(RES_DISARM) or s_frame_end(RES_WRITE) or s_frame_end(RES_STORE)
      |=> !q.write_enable_latch_flag)
    else $error("latch survived a write-class frame");
  a_pin_guard: assert property (@(posedge clk) disable iff (!rst_n)
    s_frame_end(RES_STORE) ##0 (q.pen && !q.wp2) |=> $stable({q.pen, q.bp}) && !q.nv_we)
    else $error("status store passed the guard pin");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rst_n)
    s_frame_end(RES_SLEEP) |=> q.asleep && sleep_active)
    else $error("sleep not entered");
  a_wake_busy: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(q.waking) |-> q.asleep [*4])
    else $error("woke without recovery time");
  a_commit_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (q.t2 != q.t3) |=> mem_we ##1 !mem_we)
    else $error("array strobe not a single pulse");
endmodule // spnv_top

`default_nettype wire

// ### verif/spnv_master.sv
// Serial bus master model that drives frames into the access block
`timescale 1ns/1ps
`default_nettype none

module spnv_master (
  input  wire logic mode3_sel, // Idle clock level, 1 selects mode 3
  input  wire logic so,        // Serial data from the device
  input  wire logic so_oe_n,   // Low while the device drives so
  output logic      sck,       // Serial clock, still outside frames
  output logic      cs_n,      // Chip select
  output logic      si,        // Serial data to the device
  output logic      hold_n     // Pause pin
);
  // Idle bus at time zero
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Park the clock at its idle level before selecting
  task automatic open_f();
    sck = mode3_sel;
    #43;
    cs_n = 1'b0;
    #40;
  endtask

  // Gap keeps frame results crossing while the clock is still
  task automatic close_f();
    sck = mode3_sel;
    #40;
    cs_n = 1'b1;
    si = ~si; // Released line shows no stale bit
    #200;
  endtask

  // One byte, MSB first; output sampled on rising edges
  task automatic xb(input logic [7:0] d, input logic hold, output logic [7:0] q,
                    output int unsigned n);
    n = 0;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      if (hold && i == 3) begin
        // Pause while clock low; clock toggles and si lies meanwhile
        #4 hold_n = 1'b0;
        si = ~d[i];
        repeat (2) begin
          #32 sck = 1'b1;
          #32 sck = 1'b0;
        end
        #4 hold_n = 1'b1;
      end
      si = d[i];
      #32;
      sck = 1'b1;
      q[i] = so;
      if (so_oe_n === 1'b0) n++;
      #32;
    end
  endtask
endmodule // spnv_master

`default_nettype wire

// ### verif/spnv_top_tb.sv
// Self-checking bench for the serial nonvolatile access block
`timescale 1ns/1ps
`default_nettype none
`include "spnv_defines.svh"

module spnv_top_tb;
  import spnv_pkg::*;
  localparam logic [17:0] EDGE [4] = '{18'h2FFFE, 18'h1FFFE, 18'h3FFFE, 18'h0FFFE};
  logic              clk, rst_n, wp_n, so, so_oe_n, mem_we, nv_we, sleep_active;
  logic              spi_mode3, mode3_sel, sck, cs_n, si, hold_n, write_enable_latch_flag, pen;
  logic [17:0]       mem_raddr, mem_waddr;
  logic [7:0]        mem_rdata, mem_wdata, q, b;
  logic [2:0]        nv_guard_in, nv_guard;
  logic [1:0]        bp;
  logic [7:0]        mem [0:262143];
  logic [7:0]        ref_m [0:262143];
  logic [31:0]       seed;
  logic [23:0]       a;
  int unsigned       n, errors, check_count;

  always #10 clk = ~clk;

  // Wake time outlasts a whole dummy frame, so its opcode falls inside the wake period
  spnv_top #(.WAKE_CYCLES(64)) dut (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .nv_guard_in(nv_guard_in),
    .nv_guard(nv_guard), .nv_we(nv_we), .sleep_active(sleep_active),
    .spi_mode3(spi_mode3));
  spnv_master m (.mode3_sel(mode3_sel), .so(so), .so_oe_n(so_oe_n), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n));

  // Array and nonvolatile cells behind the block
  assign mem_rdata = mem[mem_raddr];
  always @(posedge clk) begin
    if (mem_we === 1'b1) mem[mem_waddr] <= mem_wdata;
    if (nv_we === 1'b1) nv_guard_in <= nv_guard;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Quarter, half or whole array guarded
  function automatic logic hit(input logic [17:0] p);
    return bp == 2'h3 || (bp == 2'h2 && p[17]) || (bp == 2'h1 && p[17:16] == 2'h3);
  endfunction
  function automatic logic [7:0] exp_sr();
    return {pen, 1'b1, 2'h0, bp, write_enable_latch_flag, 1'b0};
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic results();
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic op1(input logic [7:0] op);
    m.open_f();
    m.xb(op, 1'b0, q, n);
    m.close_f();
    if (op == `SPNV_OP_ARM) write_enable_latch_flag = 1'b1;
    if (op == `SPNV_OP_DISARM) write_enable_latch_flag = 1'b0;
  endtask
  task automatic fetch();
    m.open_f();
    m.xb(`SPNV_OP_FETCH, 1'b0, q, n);
    m.xb(rnd(), 1'b0, q, n);
    chk("status", exp_sr(), q);
    chk("status drive", 8, n);
    m.close_f();
  endtask
  task automatic store(input logic [7:0] v);
    m.open_f();
    m.xb(`SPNV_OP_STORE, 1'b0, q, n);
    m.xb(v, 1'b0, q, n);
    m.close_f();
    if (write_enable_latch_flag && !(pen && !wp_n)) {pen, bp} = {v[7], v[3:2]};
    write_enable_latch_flag = 1'b0;
  endtask
  task automatic hdr(input logic [7:0] op, input logic [23:0] ad);
    m.open_f();
    m.xb(op, 1'b0, q, n);
    for (int i = 2; i >= 0; i--) m.xb(ad[i*8 +: 8], 1'b0, q, n);
  endtask
  // Burst write; first data byte is paused in mid-flight
  task automatic wr(input logic [23:0] ad, input int k);
    logic [17:0] p;
    logic        stop;
    logic [7:0]  d;
    p = ad[17:0];
    stop = !write_enable_latch_flag;
    hdr(`SPNV_OP_WRITE, ad);
    for (int i = 0; i < k; i++) begin
      d = rnd();
      m.xb(d, i == 0, q, n);
      stop = stop || hit(p);
      if (!stop) begin
        ref_m[p] = d;
        p = p + 1'b1;
      end
    end
    m.close_f();
    write_enable_latch_flag = 1'b0;
  endtask
  task automatic rd(input logic [23:0] ad, input int k);
    logic [17:0] p;
    p = ad[17:0];
    hdr(`SPNV_OP_READ, ad);
    for (int i = 0; i < k; i++) begin
      m.xb(rnd(), 1'b0, q, n);
      chk("read data", ref_m[p], q);
      chk("read drive", 8, n);
      p = p + 1'b1;
    end
    m.close_f();
    chk("so release", 1'b1, so_oe_n);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    write_enable_latch_flag = 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Hang guard
  initial begin
    #2000000;
    errors++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    mode3_sel = 1'b0;
    nv_guard_in = 3'h0;
    seed = 32'h9646EDEC;
    {errors, check_count, write_enable_latch_flag, pen, bp} = '0;
    for (int i = 0; i < 262144; i++) begin
      mem[i] = 8'h5A;
      ref_m[i] = 8'h5A;
    end
    do_reset();
    fetch();
    a = {rnd(), rnd(), rnd()};
    wr(a, 3);
    rd(a, 3);
    // Guard codes 00, 01 and 10 (the 11 store is blocked by the pin), guard pin both ways, bursts across block edges
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      wp_n <= ~k[0];
      b = rnd();
      b[7] = k[1];
      b[3:2] = k[1:0];
      op1(`SPNV_OP_ARM);
      fetch();
      store(b);
      fetch();
      op1(`SPNV_OP_ARM);
      a = {rnd(), 16'h0};
      a[17:0] = EDGE[k % 4];
      wr(a, 4);
      rd(a, 4);
    end
    @(posedge clk);
    wp_n <= 1'b1;
    op1(`SPNV_OP_ARM);
    store(8'h00);
    op1(`SPNV_OP_ARM);
    op1(`SPNV_OP_DISARM);
    fetch();
    wr(a, 2);
    op1(`SPNV_OP_ARM);
    wr(24'hFFFFFF, 2);
    rd(24'hC3FFFF, 2);
    // Unknown opcode keeps the output released
    m.open_f();
    m.xb(8'hAA, 1'b0, q, n);
    m.xb(`SPNV_OP_FETCH, 1'b0, q, n);
    chk("unknown op drive", 0, n);
    m.close_f();
    // Guards survive a reset; the latch, already cleared by the store, reads clear after it
    op1(`SPNV_OP_ARM);
    store(8'h84);
    do_reset();
    fetch();
    mode3_sel = 1'b1;
    fetch();
    chk("mode 3", 1'b1, spi_mode3);
    mode3_sel = 1'b0;
    // Sleep, dummy access to wake, then a real command
    op1(`SPNV_OP_SLEEP);
    repeat (8) @(posedge clk);
    chk("asleep", 1'b1, sleep_active);
    m.open_f();
    m.xb(`SPNV_OP_FETCH, 1'b0, q, n);
    m.xb(8'h00, 1'b0, q, n);
    chk("wake drive", 0, n);
    m.close_f();
    for (int i = 0; i < 200 && sleep_active !== 1'b0; i++) @(posedge clk);
    chk("awake", 1'b0, sleep_active);
    fetch();
    chk("mode 0", 1'b0, spi_mode3);
    results();
  end
endmodule // spnv_top_tb

`default_nettype wire
